//--- dv/strap_board.sv
// Board model: drives the five configuration pins from a chosen code.
module strap_board
	import strap_skew_pkg::*;
(
	input wire logic [4:0] code_i,
	output strap_t pins_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Straps are static board levels, so the model passes the code with no glitching.
	assign pins_o = code_i;
endmodule

//--- dv/test_strap_skew.sv
// Directed bench for strap decode, sticky control and deskew status.
`define CHK(n, e, s) begin \
	checked++; \
	if ((e) !== (s)) begin \
		mismatches++; \
		$display("mismatch %s exp %h got %h", n, e, s); \
	end \
end
module test_strap_skew;
	import strap_skew_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam mode_t RM = 11'h5A5;
	logic clock_i = 0, rst_b_i = 0, soft_reset_i = 0;
	logic mgmt_wr_i = 0, mgmt_rd_i = 0, skew_valid_i = 0;
	logic [4:0] code = 0, mgmt_addr_i = 0;
	logic [15:0] mgmt_wdata_i = 0, mgmt_rdata_o;
	logic [1:0] link_speed_i = SPEED_1000;
	logic [3:0][2:0] skew_meas_i = 0;
	logic [3:0][3:0] rx_sym_i = 0, rx_sym_o;
	logic [3:0] cnt = 0;
	strap_t pins;
	mode_t eff_mode_o;
	int mismatches = 0, checked = 0, cyc = 0;
	strap_board brd_u (.code_i(code), .pins_o(pins));
	// Four-bit symbols keep a seven-symbol delay from aliasing onto a shorter one.
	strap_skew #(.SYM_W(4)) dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i),
		.strap_pins_i(pins), .soft_reset_i(soft_reset_i), .mgmt_addr_i(mgmt_addr_i),
		.mgmt_wr_i(mgmt_wr_i), .mgmt_rd_i(mgmt_rd_i), .mgmt_wdata_i(mgmt_wdata_i),
		.reg_mode_i(RM), .link_speed_i(link_speed_i), .skew_valid_i(skew_valid_i),
		.skew_meas_i(skew_meas_i), .rx_sym_i(rx_sym_i), .mgmt_rdata_o(mgmt_rdata_o),
		.eff_mode_o(eff_mode_o), .rx_sym_o(rx_sym_o));
	always #50 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			summarize();
		end
	end
	task automatic summarize();
		if (mismatches == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		mgmt_addr_i = a;
		mgmt_wdata_i = d;
		mgmt_wr_i = 1;
		tick(1);
		mgmt_wr_i = 0;
		tick(1);
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		mgmt_addr_i = a;
		mgmt_rd_i = 1;
		tick(1);
		mgmt_rd_i = 0;
		`CHK("rdata", e, mgmt_rdata_o)
		tick(1);
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		tick(1);
		s = 0;
		tick(1);
	endtask
	task automatic sym_run(input logic [3:0][2:0] k);
		for (int i = 0; i < 16; i++) begin
			rx_sym_i = {4{cnt}};
			cnt++;
			tick(1);
			for (int p = 0; p < 4; p++) begin
				if (i > 7) `CHK("rx_sym", 4'(cnt - 1 - k[p]), rx_sym_o[p])
			end
		end
	endtask
	function automatic mode_t exp_mode(input logic [4:0] p);
		mode_t m;
		m = '0;
		if (p == 5'h1F) return RM;
		m.aneg_enable = !p[4];
		m.mode_valid = |p[2:0];
		if (p[4]) begin
			m.full = p[3] & m.mode_valid;
			m.speed = p[0] ? SPEED_1000 : p[1] ? SPEED_100 : SPEED_10;
		end else begin
			m.adv = {p[0] & p[3], p[0], p[1] & p[3], p[1], p[2] & p[3], p[2]};
		end
		return m;
	endfunction
	initial begin
		tick(12);
		rst_b_i = 1;
		tick(1);
		rd(SKEW_STAT_ADDR, 16'h0000);
		rd(SPARE_1E_ADDR, 16'h0000);
		rd(MODE_CTL_ADDR, 16'h0000);
		for (int c = 0; c < 32; c++) begin
			code = 5'(c);
			tick(4);
			`CHK("eff_mode", exp_mode(5'(c)), eff_mode_o)
		end
		// The host takes register control after reset; with bit 1 clear it keeps it through a soft reset.
		wr(MODE_CTL_ADDR, 16'h0004);
		code = 5'h13;
		tick(4);
		`CHK("prio_mode", RM, eff_mode_o)
		rd(MODE_CTL_ADDR, 16'h0004);
		pulse(soft_reset_i);
		rd(MODE_CTL_ADDR, 16'h0004);
		wr(MODE_CTL_ADDR, 16'h0006);
		pulse(soft_reset_i);
		rd(MODE_CTL_ADDR, 16'h0000);
		`CHK("pin_mode", exp_mode(5'h13), eff_mode_o)
		wr(SPARE_1E_ADDR, 16'hFFFF);
		rd(SPARE_1E_ADDR, 16'h0000);
		wr(SKEW_STAT_ADDR, 16'hFFFF);
		rd(SKEW_STAT_ADDR, 16'h0000);
		skew_meas_i = {3'h0, 3'h2, 3'h5, 3'h7};
		pulse(skew_valid_i);
		rd(SKEW_STAT_ADDR, 16'h7520);
		sym_run(skew_meas_i);
		link_speed_i = SPEED_100;
		skew_meas_i = {4{3'h3}};
		pulse(skew_valid_i);
		rd(SKEW_STAT_ADDR, 16'h7520);
		pulse(soft_reset_i);
		rd(SKEW_STAT_ADDR, 16'h0000);
		// Pair A at two and pair C at zero exercise both delay paths.
		link_speed_i = SPEED_1000;
		skew_meas_i = {3'h3, 3'h0, 3'h1, 3'h2};
		pulse(skew_valid_i);
		rd(SKEW_STAT_ADDR, 16'h2103);
		sym_run(skew_meas_i);
		summarize();
	end
endmodule

//--- logic/strap_skew.sv
// Strap pin decode, sticky mode control and per-pair receive deskew status.
module strap_skew
	import strap_skew_pkg::*;
#(
	parameter int SYM_W = 3
) (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire strap_t strap_pins_i,
	input wire logic soft_reset_i,
	input wire logic [4:0] mgmt_addr_i,
	input wire logic mgmt_wr_i,
	input wire logic mgmt_rd_i,
	input wire logic [15:0] mgmt_wdata_i,
	input wire mode_t reg_mode_i,
	input wire logic [1:0] link_speed_i,
	input wire logic skew_valid_i,
	input wire logic [PAIRS-1:0][SKEW_W-1:0] skew_meas_i,
	input wire logic [PAIRS-1:0][SYM_W-1:0] rx_sym_i,
	output logic [15:0] mgmt_rdata_o,
	output mode_t eff_mode_o,
	output logic [PAIRS-1:0][SYM_W-1:0] rx_sym_o
);
	strap_t meta_q;
	strap_t pins_q;
	logic pin_prio_q;
	logic reset_ctl_q;
	logic [PAIRS-1:0][SKEW_W-1:0] skew_q;
	logic [PAIRS-1:0][SKEW_MAX-1:0][SYM_W-1:0] line_q;
	mode_t strap_mode_d;
	mode_t eff_mode_d;
	logic all_high;
	logic [15:0] skew_word;
	logic [15:0] rdata_d;
	logic ctl_wr;

	// Only the second stage is looked at; the first may be metastable.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_q <= '0;
			pins_q <= '0;
		end else begin
			meta_q <= strap_pins_i;
			pins_q <= meta_q;
		end
	end

	assign all_high = &pins_q;
	assign ctl_wr = mgmt_wr_i && (mgmt_addr_i == MODE_CTL_ADDR);

	// Sticky control bits; a soft reset in the same cycle as a write wins.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pin_prio_q <= PIN_PRIO_RST;
			reset_ctl_q <= RESET_CTL_RST;
		end else if (soft_reset_i) begin
			if (reset_ctl_q) begin
				pin_prio_q <= PIN_PRIO_RST;
				reset_ctl_q <= RESET_CTL_RST;
			end
		end else if (ctl_wr) begin
			pin_prio_q <= mgmt_wdata_i[PIN_PRIO_BIT];
			reset_ctl_q <= mgmt_wdata_i[RESET_CTL_BIT];
		end
	end

	always_comb begin
		strap_mode_d = MODE_RST;
		strap_mode_d.aneg_enable = !pins_q.autoneg_inhibit_pin;
		if (!pins_q.autoneg_inhibit_pin) begin
			strap_mode_d.mode_valid = pins_q.ten_mb_strap || pins_q.hundred_mb_strap ||
				pins_q.gigabit_strap;
			strap_mode_d.adv.g_half = pins_q.gigabit_strap;
			strap_mode_d.adv.g_full = pins_q.gigabit_strap && pins_q.full_duplex_strap;
			strap_mode_d.adv.h_half = pins_q.hundred_mb_strap;
			strap_mode_d.adv.h_full = pins_q.hundred_mb_strap && pins_q.full_duplex_strap;
			strap_mode_d.adv.t_half = pins_q.ten_mb_strap;
			strap_mode_d.adv.t_full = pins_q.ten_mb_strap && pins_q.full_duplex_strap;
		end else begin
			strap_mode_d.full = pins_q.full_duplex_strap;
			strap_mode_d.mode_valid = 1'b1;
			if (pins_q.gigabit_strap) begin
				strap_mode_d.speed = SPEED_1000;
			end else if (pins_q.hundred_mb_strap) begin
				strap_mode_d.speed = SPEED_100;
			end else if (pins_q.ten_mb_strap) begin
				strap_mode_d.speed = SPEED_10;
			end else begin
				strap_mode_d.mode_valid = 1'b0;
				strap_mode_d.full = 1'b0;
			end
		end
	end

	// The register view is passed through untouched; pins never write it back.
	always_comb begin
		if (all_high || pin_prio_q) begin
			eff_mode_d = reg_mode_i;
		end else begin
			eff_mode_d = strap_mode_d;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			eff_mode_o <= MODE_RST;
		end else begin
			eff_mode_o <= eff_mode_d;
		end
	end

	// Measurements outside gigabit are not trusted, so the last value is kept.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			skew_q <= {PAIRS{SKEW_RST}};
		end else if (soft_reset_i) begin
			skew_q <= {PAIRS{SKEW_RST}};
		end else if (skew_valid_i && link_speed_i == SPEED_1000) begin
			skew_q <= skew_meas_i;
		end
	end

	genvar p;
	generate
		for (p = 0; p < PAIRS; p++) begin : g_pair
			always_ff @(posedge clock_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					line_q[p] <= '0;
					rx_sym_o[p] <= '0;
				end else begin
					line_q[p] <= {line_q[p][SKEW_MAX-2:0], rx_sym_i[p]};
					if (skew_q[p] == SKEW_RST) begin
						rx_sym_o[p] <= rx_sym_i[p];
					end else begin
						rx_sym_o[p] <= line_q[p][skew_q[p] - 3'h1];
					end
				end
			end
		end
	endgenerate

	// Pair A sits highest; each field has a reserved zero bit above it.
	assign skew_word = {1'b0, skew_q[0], 1'b0, skew_q[1], 1'b0, skew_q[2],
		1'b0, skew_q[3]};

	always_comb begin
		rdata_d = RDATA_RST;
		unique case (mgmt_addr_i)
			MODE_CTL_ADDR: begin
				rdata_d[PIN_PRIO_BIT] = pin_prio_q;
				rdata_d[RESET_CTL_BIT] = reset_ctl_q;
			end
			SKEW_STAT_ADDR: rdata_d = skew_word;
			SPARE_1E_ADDR: rdata_d = RDATA_RST;
			default: rdata_d = RDATA_RST;
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mgmt_rdata_o <= RDATA_RST;
		end else if (mgmt_rd_i) begin
			mgmt_rdata_o <= rdata_d;
		end
	end

	sticky_clear_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		soft_reset_i && reset_ctl_q |=> !pin_prio_q && !reset_ctl_q)
		else $error("sticky bits not cleared by soft reset");

	sticky_keep_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		soft_reset_i && !reset_ctl_q |=> pin_prio_q == $past(pin_prio_q))
		else $error("sticky bit changed although kept");

	adv_none_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		!pin_prio_q && pins_q == '0 |=> eff_mode_o.adv == '0 && !eff_mode_o.mode_valid)
		else $error("advertised with no speed strap");

	adv_duplex_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		!pin_prio_q && !pins_q.autoneg_inhibit_pin && pins_q.gigabit_strap
		|=> eff_mode_o.adv.g_half && eff_mode_o.adv.g_full == $past(pins_q.full_duplex_strap))
		else $error("gigabit advertisement wrong");

	force_speed_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		!pin_prio_q && !all_high && pins_q.autoneg_inhibit_pin && pins_q.gigabit_strap
		|=> eff_mode_o.speed == SPEED_1000 && !eff_mode_o.aneg_enable)
		else $error("forced gigabit not selected");

	all_high_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		all_high |=> eff_mode_o == $past(reg_mode_i))
		else $error("all pins high did not select registers");

	strap_rule_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		!pin_prio_q && !all_high |=> eff_mode_o == $past(strap_mode_d))
		else $error("strap mode not applied");

	prio_reg_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		pin_prio_q |=> eff_mode_o == $past(reg_mode_i))
		else $error("register mode not applied");

	pin_sync_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		$past(rst_b_i, 2) |-> pins_q == $past(strap_pins_i, 2))
		else $error("pin synchroniser latency wrong");

	skew_hold_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		link_speed_i != SPEED_1000 && !soft_reset_i |=> $stable(skew_q))
		else $error("skew changed outside gigabit");

	skew_read_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		mgmt_rd_i && mgmt_addr_i == SKEW_STAT_ADDR
		|=> mgmt_rdata_o[15] == 1'b0 && mgmt_rdata_o[11] == 1'b0 && mgmt_rdata_o[7] == 1'b0
		&& mgmt_rdata_o[3] == 1'b0 && mgmt_rdata_o[14:12] == $past(skew_q[0]))
		else $error("skew status layout wrong");

	spare_zero_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		mgmt_rd_i && mgmt_addr_i == SPARE_1E_ADDR |=> mgmt_rdata_o == 16'h0000)
		else $error("spare register not zero");

	delay_two_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		skew_q[0] == 3'h2 && $past(skew_q[0]) == 3'h2 && $past(rst_b_i, 3)
		|=> rx_sym_o[0] == $past(rx_sym_i[0], 3))
		else $error("pair A delay wrong");

	delay_zero_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		skew_q[2] == 3'h0 && $past(skew_q[2]) == 3'h0 |=> rx_sym_o[2] == $past(rx_sym_i[2]))
		else $error("pair C zero delay wrong");

	sticky_ctl_keep_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		soft_reset_i && !reset_ctl_q |=> !reset_ctl_q)
		else $error("reset control changed although kept");

	ctl_write_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ctl_wr && !soft_reset_i |=> pin_prio_q == $past(mgmt_wdata_i[PIN_PRIO_BIT]))
		else $error("priority bit write lost");

	ctl_read_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		mgmt_rd_i && mgmt_addr_i == MODE_CTL_ADDR
		|=> mgmt_rdata_o[2] == $past(pin_prio_q) && mgmt_rdata_o[15:3] == 13'h0000)
		else $error("control register read wrong");

	adv_hundred_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		!pin_prio_q && !pins_q.autoneg_inhibit_pin && pins_q.hundred_mb_strap
		|=> eff_mode_o.adv.h_half && eff_mode_o.aneg_enable)
		else $error("hundred advertisement wrong");

	adv_ten_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		!pin_prio_q && !pins_q.autoneg_inhibit_pin
		|=> eff_mode_o.adv.t_half == $past(pins_q.ten_mb_strap))
		else $error("ten advertisement wrong");

	adv_half_only_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		!pin_prio_q && !pins_q.autoneg_inhibit_pin && !pins_q.full_duplex_strap
		|=> !eff_mode_o.adv.g_full && !eff_mode_o.adv.h_full && !eff_mode_o.adv.t_full)
		else $error("full duplex advertised without strap");

	force_hundred_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		!pin_prio_q && pins_q.autoneg_inhibit_pin && !pins_q.gigabit_strap
		&& pins_q.hundred_mb_strap |=> eff_mode_o.speed == SPEED_100)
		else $error("forced hundred not selected");

	force_ten_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		!pin_prio_q && pins_q.autoneg_inhibit_pin && !pins_q.gigabit_strap
		&& !pins_q.hundred_mb_strap && pins_q.ten_mb_strap
		|=> eff_mode_o.speed == SPEED_10 && eff_mode_o.mode_valid)
		else $error("forced ten not selected");

	force_duplex_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		!pin_prio_q && !all_high && pins_q.autoneg_inhibit_pin
		&& (pins_q.gigabit_strap || pins_q.hundred_mb_strap || pins_q.ten_mb_strap)
		|=> eff_mode_o.full == $past(pins_q.full_duplex_strap))
		else $error("forced duplex wrong");

	force_none_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		!pin_prio_q && pins_q.autoneg_inhibit_pin && !pins_q.gigabit_strap
		&& !pins_q.hundred_mb_strap && !pins_q.ten_mb_strap |=> !eff_mode_o.mode_valid)
		else $error("forced mode without speed strap");

	force_no_adv_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		!pin_prio_q && !all_high && pins_q.autoneg_inhibit_pin |=> eff_mode_o.adv == '0)
		else $error("forced mode advertised");

	skew_clear_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		soft_reset_i |=> skew_q == '0)
		else $error("skew not cleared by soft reset");

	skew_take_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		skew_valid_i && link_speed_i == SPEED_1000 && !soft_reset_i
		|=> skew_q == $past(skew_meas_i))
		else $error("gigabit skew not taken");

	rdata_hold_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		!mgmt_rd_i |=> $stable(mgmt_rdata_o))
		else $error("read data changed without read");
endmodule

//--- logic/strap_skew_pkg.sv
// Constants and carrier types for the strap decode and deskew status block.
package strap_skew_pkg;
	localparam logic [4:0] MODE_CTL_ADDR = 5'h1C;
	localparam logic [4:0] SKEW_STAT_ADDR = 5'h1D;
	localparam logic [4:0] SPARE_1E_ADDR = 5'h1E;
	localparam int PIN_PRIO_BIT = 2;
	localparam int RESET_CTL_BIT = 1;
	localparam logic PIN_PRIO_RST = 1'b0;
	localparam logic RESET_CTL_RST = 1'b0;
	localparam logic [2:0] SKEW_RST = 3'h0;
	localparam logic [15:0] RDATA_RST = 16'h0000;
	localparam int PAIRS = 4;
	localparam int SKEW_W = 3;
	localparam int SKEW_MAX = 7;
	localparam int SYNC_STAGES = 2;
	localparam logic [1:0] SPEED_10 = 2'h0;
	localparam logic [1:0] SPEED_100 = 2'h1;
	localparam logic [1:0] SPEED_1000 = 2'h2;

	typedef struct packed {
		logic autoneg_inhibit_pin;
		logic full_duplex_strap;
		logic ten_mb_strap;
		logic hundred_mb_strap;
		logic gigabit_strap;
	} strap_t;

	// Advertised abilities, highest speed first, full before half.
	typedef struct packed {
		logic g_full;
		logic g_half;
		logic h_full;
		logic h_half;
		logic t_full;
		logic t_half;
	} adv_t;

	typedef struct packed {
		logic aneg_enable;
		logic mode_valid;
		logic [1:0] speed;
		logic full;
		adv_t adv;
	} mode_t;

	localparam mode_t MODE_RST = '0;
endpackage
